/* rtl/sdb_pkg.sv */
// sense descriptor builder: shared constants, byte positions and carriers
// assumes one core clock; every offset is a byte index into the report
package sdb_pkg;

   // ----------------------------------------------------------------
   // report geometry
   // ----------------------------------------------------------------
   localparam int          REPORT_LEN  = 60;
   localparam logic [5:0]  LAST_IDX    = 6'h3b;   // byte 59
   localparam logic [7:0]  ADD_SENSE_LEN = 8'h34; // bytes that follow byte 7
   localparam int          FIFO_DEPTH  = 32;
   localparam int          BEAT_W      = 9;

   // ----------------------------------------------------------------
   // header and descriptor start offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  RESP_CURRENT  = 8'h72;
   localparam logic [7:0]  RESP_DEFERRED = 8'h73;
   localparam int          OFS_HDR_LEN   = 7;
   localparam int          OFS_INFO      = 8;
   localparam int          OFS_CMD       = 20;
   localparam int          OFS_SKS       = 32;
   localparam int          OFS_UNIT      = 40;
   localparam int          OFS_BLK       = 44;
   localparam int          OFS_ERRC      = 48;
   localparam int          OFS_PER       = 52;
   localparam int          VALID_BIT     = 7;
   localparam int          LI_BIT        = 5;     // length-indicator bit in block byte 3

   // ----------------------------------------------------------------
   // descriptor type codes and additional lengths
   // ----------------------------------------------------------------
   localparam logic [7:0]  TYPE_INFO = 8'h00;
   localparam logic [7:0]  TYPE_CMD  = 8'h01;
   localparam logic [7:0]  TYPE_SKS  = 8'h02;
   localparam logic [7:0]  TYPE_UNIT = 8'h03;
   localparam logic [7:0]  TYPE_BLK  = 8'h05;
   localparam logic [7:0]  TYPE_ERRC = 8'h80;
   localparam logic [7:0]  TYPE_PER  = 8'h81;
   localparam logic [7:0]  LEN_INFO  = 8'h0a;
   localparam logic [7:0]  LEN_CMD   = 8'h0a;
   localparam logic [7:0]  LEN_SKS   = 8'h06;
   localparam logic [7:0]  LEN_UNIT  = 8'h02;
   localparam logic [7:0]  LEN_BLK   = 8'h02;
   localparam logic [7:0]  LEN_ERRC  = 8'h02;
   localparam logic [7:0]  LEN_PER   = 8'h06;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   // fixed-format field values that feed one report
   typedef struct packed {
      logic        deferred;
      logic [3:0]  sense_key;
      logic [7:0]  asc;
      logic [7:0]  ascq;
      logic        info_valid;
      logic [63:0] block_addr;
      logic [31:0] residue;
      logic        length_mismatch_flag;
      logic [31:0] cmd_info;
      logic [23:0] key_specific;   // bit 23 is specific_field_valid
      logic [7:0]  replaceable_unit_code;
      logic [15:0] unit_error_code;
      logic [47:0] phys_record;
   } sdb_fields_t;

   // one byte of the outgoing stream
   typedef struct packed {
      logic        last;
      logic [7:0]  data;
   } sdb_beat_t;

   typedef enum logic {SDB_IDLE, SDB_EMIT} sdb_state_t;

endpackage

/* rtl/sdb_fifo.sv */
// sdb_fifo: synchronous first-in first-out buffer, valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sdb_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   // ----------------------------------------------------------------
   // status; the extra pointer bit tells full from empty
   // ----------------------------------------------------------------
   assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   // pointer next values
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) begin
         next_wr_ptr = wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
   end

   // pointers only; storage has no reset to keep it as plain flops
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule

/* rtl/sdb_builder.sv */
// sdb_builder: turns one set of fixed-format error fields into the 60-byte
// descriptor-format report and streams it out a byte at a time
// assumes inputs synchronous to core_clk and a synchronous active-high reset
//
// Behaviour
// - command-specific descriptor sits in report bytes 20 to 31
// - command-specific descriptor: type 01h, additional length 0Ah
// - its bytes 4-11 carry the command-specific value; bytes 2-3 zero
// - key-specific descriptor sits in report bytes 32 to 39
// - key-specific descriptor: type 02h, additional length 06h
// - bytes 4-6 copy fixed-format bytes 15-17; byte 7 zero
// - replaceable-unit descriptor sits in bytes 40 to 43
// - replaceable-unit descriptor: type 03h, length 02h, byte 2 zero, byte 3 code
// - unit code equals the fixed-format replaceable-unit code
// - block command descriptor sits in bytes 44 to 47
// - block command descriptor: type 05h, length 02h, byte 2 zero
// - block byte 3 holds only the length-mismatch bit
// - information field: block address if bit clear, signed residue if set
// - unit-error-code descriptor sits in bytes 48 to 51
// - unit-error-code descriptor: type 80h, length 02h, code in bytes 2-3
// - unit error code equals the fixed-format vendor error value
// - physical-error-record descriptor sits in bytes 52 to 59
// - physical-error-record descriptor: type 81h, length 06h, record bytes 2-7
// - record equals fixed-format bytes 24 to 29
// - all seven descriptors always emitted in fixed order through byte 59
// - header response code 72h current, 73h deferred
`timescale 1ns/1ps
module sdb_builder (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic                 req_valid,
   output logic                      req_ready,
   input  wire sdb_pkg::sdb_fields_t req_fields,
   output logic                      out_valid,
   input  wire logic                 out_ready,
   output logic [7:0]                out_data,
   output logic                      out_last,
   output logic                      busy
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sdb_pkg::sdb_state_t  state;
   sdb_pkg::sdb_state_t  next_state;
   sdb_pkg::sdb_fields_t cap;
   sdb_pkg::sdb_fields_t next_cap;
   logic [5:0]           idx;
   logic [5:0]           next_idx;
   logic [7:0]           rpt [0:sdb_pkg::REPORT_LEN-1];
   logic [63:0]          info_word;
   sdb_pkg::sdb_beat_t   push_beat;
   sdb_pkg::sdb_beat_t   pop_beat;
   logic                 push_valid;
   logic                 push_ready;
   logic                 push;

   // byte k of a big-endian field, counted from its first byte
   function automatic logic [7:0] be_byte(input logic [63:0] v, input int nbytes, input int k);
      logic [63:0] sh;
      sh = v >> (8 * (nbytes - 1 - k));
      return sh[7:0];
   endfunction

   // ----------------------------------------------------------------
   // report assembly from the captured fields
   // ----------------------------------------------------------------
   // information field meaning follows the length-mismatch bit
   always_comb begin
      if (cap.length_mismatch_flag) begin
         info_word = {{32{cap.residue[31]}}, cap.residue};
      end else begin
         info_word = cap.block_addr;
      end
   end

   // every byte starts at zero so reserved positions stay clean
   always_comb begin
      for (int i = 0; i < sdb_pkg::REPORT_LEN; i++) begin
         rpt[i] = 8'h00;
      end
      // common header
      rpt[0] = cap.deferred ? sdb_pkg::RESP_DEFERRED : sdb_pkg::RESP_CURRENT;
      rpt[1] = {4'h0, cap.sense_key};
      rpt[2] = cap.asc;
      rpt[3] = cap.ascq;
      rpt[sdb_pkg::OFS_HDR_LEN] = sdb_pkg::ADD_SENSE_LEN;
      // information descriptor, bytes 8-19
      rpt[sdb_pkg::OFS_INFO]     = sdb_pkg::TYPE_INFO;
      rpt[sdb_pkg::OFS_INFO + 1] = sdb_pkg::LEN_INFO;
      rpt[sdb_pkg::OFS_INFO + 2][sdb_pkg::VALID_BIT] = cap.info_valid;
      for (int k = 0; k < 8; k++) begin
         rpt[sdb_pkg::OFS_INFO + 4 + k] = be_byte(info_word, 8, k);
      end
      // command-specific descriptor, bytes 20-31; 32-bit value zero-extended
      rpt[sdb_pkg::OFS_CMD]     = sdb_pkg::TYPE_CMD;
      rpt[sdb_pkg::OFS_CMD + 1] = sdb_pkg::LEN_CMD;
      for (int k = 0; k < 8; k++) begin
         rpt[sdb_pkg::OFS_CMD + 4 + k] = be_byte({32'h0, cap.cmd_info}, 8, k);
      end
      // key-specific descriptor, bytes 32-39
      rpt[sdb_pkg::OFS_SKS]     = sdb_pkg::TYPE_SKS;
      rpt[sdb_pkg::OFS_SKS + 1] = sdb_pkg::LEN_SKS;
      for (int k = 0; k < 3; k++) begin
         rpt[sdb_pkg::OFS_SKS + 4 + k] = be_byte({40'h0, cap.key_specific}, 3, k);
      end
      // replaceable-unit descriptor, bytes 40-43
      rpt[sdb_pkg::OFS_UNIT]     = sdb_pkg::TYPE_UNIT;
      rpt[sdb_pkg::OFS_UNIT + 1] = sdb_pkg::LEN_UNIT;
      rpt[sdb_pkg::OFS_UNIT + 3] = cap.replaceable_unit_code;
      // block command descriptor, bytes 44-47
      rpt[sdb_pkg::OFS_BLK]     = sdb_pkg::TYPE_BLK;
      rpt[sdb_pkg::OFS_BLK + 1] = sdb_pkg::LEN_BLK;
      rpt[sdb_pkg::OFS_BLK + 3][sdb_pkg::LI_BIT] = cap.length_mismatch_flag;
      // unit-error-code descriptor, bytes 48-51
      rpt[sdb_pkg::OFS_ERRC]     = sdb_pkg::TYPE_ERRC;
      rpt[sdb_pkg::OFS_ERRC + 1] = sdb_pkg::LEN_ERRC;
      rpt[sdb_pkg::OFS_ERRC + 2] = cap.unit_error_code[15:8];
      rpt[sdb_pkg::OFS_ERRC + 3] = cap.unit_error_code[7:0];
      // physical-error-record descriptor, bytes 52-59
      rpt[sdb_pkg::OFS_PER]     = sdb_pkg::TYPE_PER;
      rpt[sdb_pkg::OFS_PER + 1] = sdb_pkg::LEN_PER;
      for (int k = 0; k < 6; k++) begin
         rpt[sdb_pkg::OFS_PER + 2 + k] = be_byte({16'h0, cap.phys_record}, 6, k);
      end
   end

   // ----------------------------------------------------------------
   // sequencer: one request in, sixty bytes out
   // ----------------------------------------------------------------
   assign req_ready  = (state == sdb_pkg::SDB_IDLE);
   assign busy       = (state == sdb_pkg::SDB_EMIT);
   assign push_valid = (state == sdb_pkg::SDB_EMIT);
   assign push       = push_valid && push_ready;
   assign push_beat.data = rpt[idx];
   assign push_beat.last = (idx == sdb_pkg::LAST_IDX);

   // fields are frozen at acceptance so the report is self-consistent
   // even if the caller changes its inputs mid-stream
   always_comb begin
      next_state = state;
      next_cap   = cap;
      next_idx   = idx;
      case (state)
         sdb_pkg::SDB_IDLE: begin
            if (req_valid) begin
               next_cap   = req_fields;
               next_idx   = 6'h00;
               next_state = sdb_pkg::SDB_EMIT;
            end
         end
         sdb_pkg::SDB_EMIT: begin
            // a full buffer stalls the walk without losing the byte
            if (push) begin
               if (idx == sdb_pkg::LAST_IDX) begin
                  next_state = sdb_pkg::SDB_IDLE;
                  next_idx   = 6'h00;
               end else begin
                  next_idx = idx + 6'h01;
               end
            end
         end
         default: begin
            next_state = sdb_pkg::SDB_IDLE;
            next_idx   = 6'h00;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= sdb_pkg::SDB_IDLE;
         cap   <= '0;
         idx   <= 6'h00;
      end else begin
         state <= next_state;
         cap   <= next_cap;
         idx   <= next_idx;
      end
   end

   // ----------------------------------------------------------------
   // output buffer
   // ----------------------------------------------------------------
   sdb_fifo #(
      .WIDTH (sdb_pkg::BEAT_W),
      .DEPTH (sdb_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_beat),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (pop_beat)
   );

   assign out_data = pop_beat.data;
   assign out_last = pop_beat.last;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_cmd_head;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h14 |=> $past(push_beat.data) == 8'h01 && (!push || push_beat.data == 8'h0a);
   endproperty
   a_cmd_head: assert property (p_cmd_head) else $error("command-specific header wrong");

   property p_cmd_value;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h1f |-> push_beat.data == cap.cmd_info[7:0] && rpt[24] == 8'h00 && rpt[22] == 8'h00;
   endproperty
   a_cmd_value: assert property (p_cmd_value) else $error("command-specific value misplaced");

   property p_sks_body;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h24 |-> push_beat.data == cap.key_specific[23:16] && rpt[39] == 8'h00
                               && rpt[32] == 8'h02 && rpt[33] == 8'h06;
   endproperty
   a_sks_body: assert property (p_sks_body) else $error("key-specific descriptor wrong");

   property p_unit_code;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h2b |-> push_beat.data == cap.replaceable_unit_code && rpt[40] == 8'h03;
   endproperty
   a_unit_code: assert property (p_unit_code) else $error("replaceable-unit code wrong");

   property p_blk_bit;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h2f |-> push_beat.data == {2'b00, cap.length_mismatch_flag, 5'b00000};
   endproperty
   a_blk_bit: assert property (p_blk_bit) else $error("block byte 3 wrong");

   property p_info_sel;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h13 |->
         push_beat.data == (cap.length_mismatch_flag ? cap.residue[7:0] : cap.block_addr[7:0]);
   endproperty
   a_info_sel: assert property (p_info_sel) else $error("information field source wrong");

   property p_errc;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h32 |-> push_beat.data == cap.unit_error_code[15:8] && rpt[48] == 8'h80;
   endproperty
   a_errc: assert property (p_errc) else $error("unit error code wrong");

   property p_per;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h3b |-> push_beat.data == cap.phys_record[7:0] && rpt[52] == 8'h81;
   endproperty
   a_per: assert property (p_per) else $error("physical record wrong");

   // helper for the order check: pushes counted apart from idx, so a
   // walk that skips or repeats a byte cannot still end on byte 59
   logic [6:0] n_pushed;
   logic [6:0] next_n_pushed;

   // count restarts when a report is taken
   always_comb begin
      next_n_pushed = n_pushed;
      if (req_valid && req_ready) begin
         next_n_pushed = 7'h00;
      end else if (push) begin
         next_n_pushed = n_pushed + 7'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         n_pushed <= 7'h00;
      end else begin
         n_pushed <= next_n_pushed;
      end
   end

   property p_take;
      @(posedge core_clk) disable iff (reset)
      req_valid && req_ready |=> busy && !req_ready && push_valid && idx == 6'h00;
   endproperty
   a_take: assert property (p_take) else $error("report did not start at byte 0");

   property p_reserved;
      @(posedge core_clk) disable iff (reset)
      push && (idx inside {6'h04, 6'h05, 6'h06, 6'h0b, 6'h16, 6'h17, 6'h22, 6'h23, 6'h27, 6'h2a, 6'h2e})
         |-> push_beat.data == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved byte not zero");

   property p_blk_head;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h2c |-> push_beat.data == 8'h05 && rpt[45] == 8'h02 && rpt[46] == 8'h00;
   endproperty
   a_blk_head: assert property (p_blk_head) else $error("block command header wrong");

   property p_order;
      @(posedge core_clk) disable iff (reset)
      push && push_beat.last |-> idx == 6'h3b && n_pushed == 7'h3b ##1 state == sdb_pkg::SDB_IDLE;
   endproperty
   a_order: assert property (p_order) else $error("report did not end at byte 59");

   property p_resp;
      @(posedge core_clk) disable iff (reset)
      push && idx == 6'h00 |-> push_beat.data == (cap.deferred ? 8'h73 : 8'h72);
   endproperty
   a_resp: assert property (p_resp) else $error("response code wrong");

   c_current:  cover property (@(posedge core_clk) disable iff (reset) push && idx == 6'h00 && !cap.deferred);
   c_deferred: cover property (@(posedge core_clk) disable iff (reset) push && idx == 6'h00 && cap.deferred);
   c_stall:    cover property (@(posedge core_clk) disable iff (reset) push_valid && !push_ready);
   c_done:     cover property (@(posedge core_clk) disable iff (reset) out_valid && out_ready && out_last);

endmodule

/* bench/sdb_reader.sv */
// sdb_reader: behavioural stand-in for the initiator that drains the report
// assumes the builder's byte stream on core_clk; keeps every accepted byte
`timescale 1ns/1ps
module sdb_reader (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       out_valid,
   output logic            out_ready,
   input  wire logic [7:0] out_data,
   input  wire logic       out_last,
   input  wire logic       stall_en
);
   // ----------------------------------------------------------------
   // acceptance pacing and capture
   // ----------------------------------------------------------------
   logic [8:0] got[$];
   logic [3:0] cnt = 4'h0;

   // slow pace takes one byte in four so the buffer fills and pushes stall
   always @(negedge core_clk) begin
      cnt       <= cnt + 4'h1;
      out_ready <= !reset && (!stall_en || cnt[3:2] == 2'b11);
   end

   // a byte counts only at an edge where both sides agree
   always @(posedge core_clk) begin
      if (!reset && out_valid && out_ready) begin
         got.push_back({out_last, out_data});
      end
   end
endmodule

/* bench/tb.sv */
// tb: self-checking bench for the report builder with a draining reader
// assumes inputs driven at the falling edge and a 100 MHz core clock
`timescale 1ns/1ps
module tb;
   // ----------------------------------------------------------------
   // signals and bookkeeping
   // ----------------------------------------------------------------
   logic                 core_clk   = 1'b0;
   logic                 reset      = 1'b1;
   logic                 req_valid  = 1'b0;
   logic                 stall_en   = 1'b0;
   logic                 req_ready;
   logic                 out_valid;
   logic                 out_ready;
   logic                 out_last;
   logic                 busy;
   logic [7:0]           out_data;
   sdb_pkg::sdb_fields_t req_fields = '0;
   logic [8:0]           exp_q[$];
   logic [31:0]          seed       = 32'hceac;
   int                   n_errors   = 0;
   int                   num_checks = 0;
   int                   cyc        = 0;

   always #5 core_clk = ~core_clk;

   sdb_builder sdb_builder_i (
      .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
      .req_fields(req_fields), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_last(out_last), .busy(busy));

   sdb_reader sdb_reader_i (
      .core_clk(core_clk), .reset(reset), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_last(out_last), .stall_en(stall_en));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0);
      return seed;
   endfunction

   function automatic sdb_pkg::sdb_fields_t rand_fields();
      logic [255:0] w;
      w = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      return w[$bits(sdb_pkg::sdb_fields_t)-1:0];
   endfunction

   // expected 60 bytes, worked out from the descriptor layout, big-endian fields
   function automatic void expect_report(input sdb_pkg::sdb_fields_t f);
      logic [7:0]  b[60];
      logic [63:0] info;
      foreach (b[i]) b[i] = 8'h00;
      info = f.length_mismatch_flag ? {{32{f.residue[31]}}, f.residue} : f.block_addr;
      b[0] = f.deferred ? 8'h73 : 8'h72;
      b[1] = {4'h0, f.sense_key};
      b[2] = f.asc;
      b[3] = f.ascq;
      b[7] = 8'h34;
      b[9] = 8'h0a;
      b[10] = {f.info_valid, 7'h00};
      for (int i = 0; i < 8; i++) b[12+i] = info[63-8*i -: 8];
      b[20] = 8'h01;
      b[21] = 8'h0a;
      for (int i = 0; i < 4; i++) b[28+i] = f.cmd_info[31-8*i -: 8];
      b[32] = 8'h02;
      b[33] = 8'h06;
      for (int i = 0; i < 3; i++) b[36+i] = f.key_specific[23-8*i -: 8];
      b[40] = 8'h03;
      b[41] = 8'h02;
      b[43] = f.replaceable_unit_code;
      b[44] = 8'h05;
      b[45] = 8'h02;
      b[47] = {2'b00, f.length_mismatch_flag, 5'b00000};
      b[48] = 8'h80;
      b[49] = 8'h02;
      b[50] = f.unit_error_code[15:8];
      b[51] = f.unit_error_code[7:0];
      b[52] = 8'h81;
      b[53] = 8'h06;
      for (int i = 0; i < 6; i++) b[54+i] = f.phys_record[47-8*i -: 8];
      foreach (b[i]) exp_q.push_back({(i == 59), b[i]});
   endfunction

   task automatic bad(input string msg);
      n_errors++;
      $display("BAD t=%0t %s", $time, msg);
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // offer one request, held until taken, then withdrawn; the next is raised while busy
   task automatic send(input sdb_pkg::sdb_fields_t f);
      int w;
      w = 0;
      req_fields = f;
      req_valid  = 1'b1;
      while (req_ready !== 1'b1 && w < 3000) begin
         @(negedge core_clk);
         w++;
      end
      if (w >= 3000) bad("request never taken");
      @(negedge core_clk);
      req_valid = 1'b0;
      expect_report(f);
      num_checks++;
      if (busy !== 1'b1 || req_ready !== 1'b0) bad("not busy after acceptance");
      // scrambled fields after acceptance must not leak into the report
      repeat (3) @(negedge core_clk);
      req_fields = ~f;
      @(negedge core_clk);
   endtask

   // compare one byte range of report r, last marker included
   task automatic chk(input int r, input int lo, input int hi);
      for (int i = lo; i <= hi; i++) begin
         num_checks++;
         if (sdb_reader_i.got[r*60+i] !== exp_q[r*60+i]) begin
            bad($sformatf("report %0d byte %0d got %h want %h", r, i,
                          sdb_reader_i.got[r*60+i], exp_q[r*60+i]));
         end
      end
   endtask

   // ----------------------------------------------------------------
   // hang guard
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad("timeout");
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      sdb_pkg::sdb_fields_t f;
      int w;
      repeat (5) @(negedge core_clk);
      reset = 1'b0;
      // corner cases: all zero, all ones deferred, negative residue
      send('0);
      f = '1;
      send(f);
      f = rand_fields();
      f.length_mismatch_flag = 1'b1;
      f.residue = 32'hffff_fff0;
      f.deferred = 1'b0;
      send(f);
      // random reports, half of them against a stalling reader
      for (int n = 0; n < 10; n++) begin
         stall_en = (n >= 5);
         send(rand_fields());
      end
      req_valid = 1'b0;
      w = 0;
      while (sdb_reader_i.got.size() < exp_q.size() && w < 5000) begin
         @(negedge core_clk);
         w++;
      end
      repeat (4) @(negedge core_clk);
      num_checks++;
      if (sdb_reader_i.got.size() != exp_q.size() || out_valid !== 1'b0) bad("byte count wrong");
      for (int r = 0; r < exp_q.size() / 60; r++) begin
         chk(r, 0, 7);
         chk(r, 8, 19);
         chk(r, 20, 31);
         chk(r, 32, 39);
         chk(r, 40, 43);
         chk(r, 44, 47);
         chk(r, 48, 51);
         chk(r, 52, 59);
      end
      give_verdict();
   end
endmodule
